// ==== rtl/timing_measurement_control_config.v ====
// timing and measurement configuration registers with timebase and detect chaining
`timescale 1ns/100ps
`include "timing_measurement_control_config_defs.vh"

module timing_measurement_control_config #(
	parameter SAMPLE_BASE_CYCLES = `CLK_FREQ_HZ / `FASTEST_RATE_HZ,
	parameter MS_CYCLES          = `CLK_FREQ_HZ / `MS_PER_S
) (
	input  wire       CLK,
	input  wire       NRST,
	input  wire [7:0] REG_ADDR,
	input  wire [7:0] REG_WDATA,
	input  wire       REG_WR,
	input  wire       REG_RD,
	output reg  [7:0] REG_RDATA,
	output reg        REG_ACK,
	input  wire       STATUS_READ,
	input  wire       MOTION_DETECT_ENABLE,
	input  wire       STILLNESS_DETECT_ENABLE,
	input  wire       MOTION_EVENT,
	input  wire       STILLNESS_EVENT,
	input  wire       WAKE_MODE_SELECT,
	input  wire       INTERRUPT_PIN_ONE_IN,
	input  wire       TRIGGER_IN,
	output reg        INTERRUPT_PIN_ONE_DRIVE_EN,
	output reg        SAMPLE_TICK,
	output reg        WAKE_TIMER_TICK,
	output reg  [2:0] OUTPUT_RATE_SELECT,
	output reg  [2:0] WAKE_TIMER_PERIOD,
	output reg  [2:0] BANDWIDTH_SELECT,
	output reg  [1:0] DETECT_CHAINING_SELECT,
	output reg        LOW_NOISE_ENABLE,
	output reg        OVERRANGE_DISABLE,
	output reg        EXTERNAL_CLOCK_ENABLE,
	output reg        EXTERNAL_TRIGGER_ENABLE,
	output reg        MOTION_ARMED,
	output reg        STILLNESS_ARMED,
	output reg        MOTION_FLAG,
	output reg        STILLNESS_FLAG,
	output reg        AUTO_SLEEP_ACTIVE
);

	localparam ARM_MOTION = 1'b0;
	localparam ARM_STILL  = 1'b1;

	////////////////////////////////////////////////////////////////////////////////

	// reserved codes fall back to the highest defined code
	function [2:0] clamp_code;
		input [2:0] code;
		input [2:0] max_code;
		begin
			clamp_code = (code > max_code) ? max_code : code;
		end
	endfunction

	function [14:0] wake_ms;
		input [2:0] code;
		begin
			case (code)
				3'h0: wake_ms = `WAKE_MS_0;
				3'h1: wake_ms = `WAKE_MS_1;
				3'h2: wake_ms = `WAKE_MS_2;
				3'h3: wake_ms = `WAKE_MS_3;
				3'h4: wake_ms = `WAKE_MS_4;
				3'h5: wake_ms = `WAKE_MS_5;
				3'h6: wake_ms = `WAKE_MS_6;
				default: wake_ms = `WAKE_MS_7;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	reg  [7:0]  timing_q;
	reg  [7:0]  measurement_control_q;
	reg         pin_prev_q;
	reg         trig_prev_q;
	reg  [16:0] samp_cnt_q;
	reg  [15:0] ms_cnt_q;
	reg  [14:0] wake_cnt_q;
	reg         state_q;
	reg         state_d;

	wire [2:0]  rate_code;
	wire [2:0]  bw_code;
	wire [2:0]  wake_code;
	wire [1:0]  chain_raw;
	wire        external_clock_enable;
	wire        ext_trig;
	wire        chained;
	wire        looped;
	wire        auto_sleep_en;
	wire        pin_edge;
	wire        trig_edge;
	wire        tb_en;
	wire [2:0]  rate_shift;
	wire [31:0] samp_span;
	wire [31:0] samp_last;
	wire        samp_wrap;
	wire [31:0] ms_last;
	wire        ms_wrap;
	wire [14:0] wake_last;
	wire        wake_wrap;
	wire        wake_active;
	wire        motion_hit;
	wire        still_hit;
	wire        hit_timing;
	wire        hit_measurement_control;

	assign rate_code     = clamp_code(timing_q[`RATE_SEL_MSB:`RATE_SEL_LSB], `RATE_CODE_MAX);
	assign bw_code       = clamp_code(measurement_control_q[`BW_SEL_MSB:`BW_SEL_LSB], `BW_CODE_MAX);
	assign wake_code     = timing_q[`WAKE_SEL_MSB:`WAKE_SEL_LSB];
	assign chain_raw     = measurement_control_q[`CHAIN_MSB:`CHAIN_LSB];
	assign external_clock_enable       = timing_q[`EXTERNAL_CLOCK_ENABLE_BIT];
	assign ext_trig      = timing_q[`EXT_TRIG_BIT];

	// chaining needs both detectors enabled, else concurrent
	assign chained       = MOTION_DETECT_ENABLE && STILLNESS_DETECT_ENABLE &&
	                       (chain_raw == `CHAIN_LINKED || chain_raw == `CHAIN_LOOPED);
	assign looped        = chained && (chain_raw == `CHAIN_LOOPED);
	assign auto_sleep_en = measurement_control_q[`AUTO_SLEEP_BIT] && chained;

	assign hit_timing    = (REG_ADDR == `TIMING_CONTROL_ADDR);
	assign hit_measurement_control   = (REG_ADDR == `MEASUREMENT_CONTROL_ADDR);

	////////////////////////////////////////////////////////////////////////////////
	// register file

	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			timing_q  <= `TIMING_CONTROL_RESET;
			measurement_control_q <= `MEASUREMENT_CONTROL_RESET;
			REG_RDATA <= 8'h00;
			REG_ACK   <= 1'b0;
		end else begin
			if (REG_WR && hit_timing) begin
				timing_q <= REG_WDATA;
			end
			if (REG_WR && hit_measurement_control) begin
				measurement_control_q <= REG_WDATA;
			end
			REG_ACK <= REG_RD && (hit_timing || hit_measurement_control);
			if (REG_RD) begin
				if (hit_timing) begin
					REG_RDATA <= timing_q;
				end else if (hit_measurement_control) begin
					REG_RDATA <= measurement_control_q;
				end else begin
					REG_RDATA <= 8'h00;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// timebase: internal clock or edges of pin one

	assign pin_edge  = INTERRUPT_PIN_ONE_IN && !pin_prev_q;
	assign trig_edge = TRIGGER_IN && !trig_prev_q;
	assign tb_en     = external_clock_enable ? pin_edge : 1'b1;

	assign rate_shift = `RATE_CODE_MAX - rate_code;
	assign samp_span  = SAMPLE_BASE_CYCLES << rate_shift;
	assign samp_last  = samp_span - 32'h00000001;
	assign samp_wrap  = ({15'h0000, samp_cnt_q} >= samp_last);

	assign ms_last    = MS_CYCLES - 32'h00000001;
	assign ms_wrap    = ({16'h0000, ms_cnt_q} >= ms_last);
	assign wake_last  = wake_ms(wake_code) - 15'h0001;
	assign wake_wrap  = (wake_cnt_q >= wake_last);
	assign wake_active = WAKE_MODE_SELECT || AUTO_SLEEP_ACTIVE;

	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			pin_prev_q      <= 1'b0;
			trig_prev_q     <= 1'b0;
			samp_cnt_q      <= 17'h00000;
			ms_cnt_q        <= 16'h0000;
			wake_cnt_q      <= 15'h0000;
			SAMPLE_TICK     <= 1'b0;
			WAKE_TIMER_TICK <= 1'b0;
		end else begin
			pin_prev_q  <= INTERRUPT_PIN_ONE_IN;
			trig_prev_q <= TRIGGER_IN;
			if (tb_en) begin
				if (samp_wrap) begin
					samp_cnt_q <= 17'h00000;
				end else begin
					samp_cnt_q <= samp_cnt_q + 17'h00001;
				end
			end
			// trigger edges replace the rate divider when enabled
			SAMPLE_TICK <= ext_trig ? trig_edge : (tb_en && samp_wrap);
			if (!wake_active) begin
				ms_cnt_q   <= 16'h0000;
				wake_cnt_q <= 15'h0000;
				WAKE_TIMER_TICK <= 1'b0;
			end else if (tb_en) begin
				WAKE_TIMER_TICK <= 1'b0;
				if (ms_wrap) begin
					ms_cnt_q <= 16'h0000;
					if (wake_wrap) begin
						wake_cnt_q      <= 15'h0000;
						WAKE_TIMER_TICK <= 1'b1;
					end else begin
						wake_cnt_q <= wake_cnt_q + 15'h0001;
					end
				end else begin
					ms_cnt_q <= ms_cnt_q + 16'h0001;
				end
			end else begin
				WAKE_TIMER_TICK <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// detect chaining

	assign motion_hit = MOTION_EVENT &&
	                    (chained ? (state_q == ARM_MOTION) : MOTION_DETECT_ENABLE);
	assign still_hit  = STILLNESS_EVENT &&
	                    (chained ? (state_q == ARM_STILL) : STILLNESS_DETECT_ENABLE);

	always @* begin
		state_d = state_q;
		if (!chained) begin
			state_d = ARM_MOTION;
		end else begin
			case (state_q)
				ARM_MOTION: begin
					if (MOTION_EVENT) begin
						state_d = ARM_STILL;
					end
				end
				ARM_STILL: begin
					if (STILLNESS_EVENT) begin
						state_d = ARM_MOTION;
					end
				end
				default: begin
					state_d = ARM_MOTION;
				end
			endcase
		end
	end

	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_q           <= ARM_MOTION;
			MOTION_ARMED      <= 1'b0;
			STILLNESS_ARMED   <= 1'b0;
			MOTION_FLAG       <= 1'b0;
			STILLNESS_FLAG    <= 1'b0;
			AUTO_SLEEP_ACTIVE <= 1'b0;
		end else begin
			state_q         <= state_d;
			MOTION_ARMED    <= chained ? (state_d == ARM_MOTION) : MOTION_DETECT_ENABLE;
			STILLNESS_ARMED <= chained ? (state_d == ARM_STILL) : STILLNESS_DETECT_ENABLE;
			// set wins over a status read; looped mode acknowledges by itself
			MOTION_FLAG    <= motion_hit || (!looped && MOTION_FLAG && !STATUS_READ);
			STILLNESS_FLAG <= still_hit || (!looped && STILLNESS_FLAG && !STATUS_READ);
			AUTO_SLEEP_ACTIVE <= auto_sleep_en &&
			                     (still_hit || (AUTO_SLEEP_ACTIVE && !motion_hit));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration outputs

	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			INTERRUPT_PIN_ONE_DRIVE_EN <= 1'b1;
			OUTPUT_RATE_SELECT         <= 3'h0;
			WAKE_TIMER_PERIOD          <= 3'h0;
			BANDWIDTH_SELECT           <= 3'h0;
			DETECT_CHAINING_SELECT     <= `CHAIN_CONCURRENT;
			LOW_NOISE_ENABLE           <= 1'b0;
			OVERRANGE_DISABLE          <= 1'b0;
			EXTERNAL_CLOCK_ENABLE      <= 1'b0;
			EXTERNAL_TRIGGER_ENABLE    <= 1'b0;
		end else begin
			INTERRUPT_PIN_ONE_DRIVE_EN <= !external_clock_enable;
			OUTPUT_RATE_SELECT         <= rate_code;
			WAKE_TIMER_PERIOD          <= wake_code;
			BANDWIDTH_SELECT           <= bw_code;
			DETECT_CHAINING_SELECT     <= chained ? chain_raw : `CHAIN_CONCURRENT;
			LOW_NOISE_ENABLE           <= measurement_control_q[`LOW_NOISE_BIT];
			OVERRANGE_DISABLE          <= measurement_control_q[`OVERRANGE_DIS_BIT];
			EXTERNAL_CLOCK_ENABLE      <= external_clock_enable;
			EXTERNAL_TRIGGER_ENABLE    <= ext_trig;
		end
	end

endmodule

// ==== pkg/timing_measurement_control_config_defs.vh ====
// constants for the timing and measurement configuration registers
`ifndef TIMING_MEASUREMENT_CONTROL_CONFIG_DEFS_VH
`define TIMING_MEASUREMENT_CONTROL_CONFIG_DEFS_VH

`define CLK_FREQ_HZ               40000000
`define FASTEST_RATE_HZ           6400
`define MS_PER_S                  1000

`define TIMING_CONTROL_ADDR       8'h3D
`define MEASUREMENT_CONTROL_ADDR  8'h3E
`define TIMING_CONTROL_RESET      8'h00
`define MEASUREMENT_CONTROL_RESET 8'h00

`define RATE_SEL_MSB              7
`define RATE_SEL_LSB              5
`define WAKE_SEL_MSB              4
`define WAKE_SEL_LSB              2
`define EXTERNAL_CLOCK_ENABLE_BIT               1
`define EXT_TRIG_BIT              0

`define OVERRANGE_DIS_BIT         7
`define AUTO_SLEEP_BIT            6
`define CHAIN_MSB                 5
`define CHAIN_LSB                 4
`define LOW_NOISE_BIT             3
`define BW_SEL_MSB                2
`define BW_SEL_LSB                0

`define RATE_CODE_MAX             3'h4
`define BW_CODE_MAX               3'h4
`define CHAIN_CONCURRENT          2'h0
`define CHAIN_LINKED              2'h1
`define CHAIN_LOOPED              2'h2

`define WAKE_MS_0                 15'h0034
`define WAKE_MS_1                 15'h0068
`define WAKE_MS_2                 15'h00D0
`define WAKE_MS_3                 15'h0200
`define WAKE_MS_4                 15'h0800
`define WAKE_MS_5                 15'h1000
`define WAKE_MS_6                 15'h2000
`define WAKE_MS_7                 15'h6000

`endif

// ==== verification/timing_measurement_control_config_assertions.sv ====
// concurrent checks on the configuration register block ports
`timescale 1ns/100ps
module timing_measurement_control_config_assertions (
	input wire       CLK,
	input wire       NRST,
	input wire [7:0] REG_ADDR,
	input wire       REG_RD,
	input wire [7:0] REG_RDATA,
	input wire       REG_ACK,
	input wire       STATUS_READ,
	input wire       MOTION_DETECT_ENABLE,
	input wire       MOTION_FLAG,
	input wire       SAMPLE_TICK,
	input wire       EXTERNAL_CLOCK_ENABLE,
	input wire       INTERRUPT_PIN_ONE_DRIVE_EN,
	input wire [2:0] OUTPUT_RATE_SELECT,
	input wire [2:0] BANDWIDTH_SELECT,
	input wire [1:0] DETECT_CHAINING_SELECT
);
	wire mapped = REG_ADDR == 8'h3D || REG_ADDR == 8'h3E;
	default clocking dc @(posedge CLK);
	endclocking
	default disable iff (!NRST);
	a_read_ack: assert property (REG_RD && mapped |=> REG_ACK)
		else $error("read not acknowledged");
	a_unmapped_read: assert property (REG_RD && !mapped |=> REG_RDATA == 8'h00 && !REG_ACK)
		else $error("unmapped read answered");
	a_rate_clamp: assert property (OUTPUT_RATE_SELECT <= 3'h4)
		else $error("rate code above four");
	a_bw_clamp: assert property (BANDWIDTH_SELECT <= 3'h4)
		else $error("bandwidth code above four");
	a_pin_input: assert property ($rose(EXTERNAL_CLOCK_ENABLE) |-> ##[0:1] !INTERRUPT_PIN_ONE_DRIVE_EN)
		else $error("pin one still driven");
	a_tick_pulse: assert property (SAMPLE_TICK |=> !SAMPLE_TICK)
		else $error("sample tick too long");
	a_chain_gate: assert property (!MOTION_DETECT_ENABLE |=> DETECT_CHAINING_SELECT == 2'h0)
		else $error("chaining without both enables");
	// the shown chaining lags the internal mode by a cycle after a register write
	a_flag_sticky: assert property (MOTION_FLAG && !STATUS_READ && DETECT_CHAINING_SELECT != 2'h2
		##1 DETECT_CHAINING_SELECT != 2'h2 |-> MOTION_FLAG)
		else $error("flag lost without status read");
endmodule

// ==== verification/reg_host.sv ====
// host model issuing register writes, reads and status reads
`timescale 1ns/100ps
module reg_host (
	input  wire       clk,
	input  wire [7:0] rdata,
	input  wire       ack,
	output reg  [7:0] addr = 8'h00,
	output reg  [7:0] wdata = 8'h00,
	output reg        wr = 1'b0,
	output reg        rd = 1'b0,
	output reg        stat = 1'b0
);
	// s picks write, read or status read; released bus shows inverted values
	task xfer(input [2:0] s, input [7:0] a, input [7:0] d, output [7:0] q, output k);
		begin
			@(posedge clk) #2;
			{wr, rd, stat, addr, wdata} = {s, a, d};
			@(posedge clk) #2;
			{wr, rd, stat, addr, wdata, q, k} = {3'h0, ~a, ~d, rdata, ack};
		end
	endtask
endmodule

// ==== verification/timing_measurement_control_config_test.sv ====
// self-checking bench for the configuration register block
`timescale 1ns/100ps
module timing_measurement_control_config_test;
	localparam SB = 4;
	localparam MS = 3;
	reg         clk = 1'b0;
	reg         nrst = 1'b0;
	reg         m_en = 1'b0;
	reg         s_en = 1'b0;
	reg         m_ev = 1'b0;
	reg         s_ev = 1'b0;
	reg         wake = 1'b0;
	reg         pin = 1'b0;
	reg         trig = 1'b0;
	reg         pin_run = 1'b0;
	wire [7:0]  addr, wdata, rdata;
	wire [2:0]  rate, wper, bw;
	wire [1:0]  chain;
	wire        wr, rd, stat, ack, pin_en, tick, wtick;
	wire        lown, ovr, extc, extt, m_arm, s_arm, m_flg, s_flg, sleep;
	wire [4:0]  dst = {m_flg, s_flg, m_arm, s_arm, sleep};
	int         bad_count = 0;
	int         cmp_count = 0;
	int         i;
	reg  [7:0]  a, d, got;
	reg  [2:0]  e;
	reg  [15:0] n;
	reg         k;
	reg  [18:0] rows [0:14] = '{{8'h3D,8'h00,3'h0}, {8'h3D,8'h9F,3'h4}, {8'h3D,8'hE2,3'h4},
		{8'h3D,8'h2D,3'h1}, {8'h3D,8'h49,3'h2}, {8'h3D,8'h74,3'h3}, {8'h3D,8'hB0,3'h4},
		{8'h3D,8'hD8,3'h4}, {8'h3D,8'h24,3'h1}, {8'h3E,8'h8C,3'h4}, {8'h3E,8'h07,3'h4},
		{8'h3E,8'h0B,3'h3}, {8'h3E,8'h01,3'h1}, {8'h3E,8'h42,3'h2}, {8'h3E,8'h30,3'h0}};
	always #12.5 clk = ~clk;
	// external clock source on pin one: one rising edge every two cycles while running
	always @(posedge clk) #2 if (pin_run) pin = ~pin;
	reg_host reg_host_i (.clk(clk), .rdata(rdata), .ack(ack), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .stat(stat));
	timing_measurement_control_config #(.SAMPLE_BASE_CYCLES(SB), .MS_CYCLES(MS)) timing_measurement_control_config_i (
		.CLK(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
		.REG_RDATA(rdata), .REG_ACK(ack), .STATUS_READ(stat), .MOTION_DETECT_ENABLE(m_en),
		.STILLNESS_DETECT_ENABLE(s_en), .MOTION_EVENT(m_ev), .STILLNESS_EVENT(s_ev),
		.WAKE_MODE_SELECT(wake), .INTERRUPT_PIN_ONE_IN(pin), .TRIGGER_IN(trig),
		.INTERRUPT_PIN_ONE_DRIVE_EN(pin_en), .SAMPLE_TICK(tick), .WAKE_TIMER_TICK(wtick),
		.OUTPUT_RATE_SELECT(rate), .WAKE_TIMER_PERIOD(wper), .BANDWIDTH_SELECT(bw),
		.DETECT_CHAINING_SELECT(chain), .LOW_NOISE_ENABLE(lown), .OVERRANGE_DISABLE(ovr),
		.EXTERNAL_CLOCK_ENABLE(extc), .EXTERNAL_TRIGGER_ENABLE(extt), .MOTION_ARMED(m_arm),
		.STILLNESS_ARMED(s_arm), .MOTION_FLAG(m_flg), .STILLNESS_FLAG(s_flg),
		.AUTO_SLEEP_ACTIVE(sleep));
	////////////////////////////////////////////////////////////////////////////////////////////
	task chk(input string s, input [15:0] x, input [15:0] g);
		begin
			cmp_count++;
			if (g !== x) begin
				bad_count++;
				$display("BAD %s expected %h seen %h", s, x, g);
			end
		end
	endtask
	task wreg(input [7:0] ra, input [7:0] rv);
		reg_host_i.xfer(3'h4, ra, rv, got, k);
	endtask
	// skips to the next tick, then counts cycles to the one after
	task gap(input w, output [15:0] c);
		begin
			c = 0;
			while ((w ? wtick : tick) !== 1'b1 && c < 2000) begin
				@(posedge clk) #2;
				c++;
			end
			c = 0;
			do begin
				@(posedge clk) #2;
				c++;
			end while ((w ? wtick : tick) !== 1'b1 && c < 2000);
		end
	endtask
	task ev(input m);
		begin
			@(posedge clk) #2;
			{m_ev, s_ev} = {m, !m};
			@(posedge clk) #2;
			{m_ev, s_ev} = 2'h0;
		end
	endtask
	task give_verdict;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
			if (bad_count == 0 && cmp_count > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		bad_count++;
		give_verdict;
	end
	initial begin
		repeat (16) @(posedge clk);
		#2 nrst = 1'b1;
		for (i = 0; i < 15; i++) begin
			{a, d, e} = rows[i];
			wreg(a, d);
			reg_host_i.xfer(3'h2, a, 8'h00, got, k);
			chk("readback", {1'b1, d}, {k, got});
			if (a == 8'h3D) begin
				chk("rate", e, rate);
				chk("wake", d[4:2], wper);
				chk("pin", {d[1], !d[1]}, {extc, pin_en});
				chk("trig", d[0], extt);
			end else begin
				chk("bw", e, bw);
				chk("noise", d[3], lown);
				chk("ovr", d[7], ovr);
				chk("chain", 2'h0, chain);
			end
			$display("row %0d done", i);
		end
		wreg(8'h3D, 8'h9F);
		@(posedge clk) #2 nrst = 1'b0;
		#1 chk("pin", 2'h1, {extc, pin_en});
		repeat (16) @(posedge clk);
		#2 nrst = 1'b1;
		wreg(8'h3F, 8'hFF);
		for (i = 0; i < 3; i++) begin
			reg_host_i.xfer(3'h2, 8'h3D + i, 8'h00, got, k);
			chk("reset", {i < 2, 8'h00}, {k, got});
		end
		$display("reset test done");
		for (i = 0; i < 4; i++) begin
			d = 8'h80 >> i;
			wreg(8'h3D, d);
			gap(0, n);
			gap(0, n);
			chk("period", SB << (4 - d[7:5]), n);
		end
		wreg(8'h3D, 8'h04);
		wake = 1'b1;
		gap(1, n);
		gap(1, n);
		chk("wake", 104 * MS, n);
		wake = 1'b0;
		wreg(8'h3D, 8'h82);
		pin_run = 1'b1;
		gap(0, n);
		gap(0, n);
		chk("extclk", 8, n);
		pin_run = 1'b0;
		n = 0;
		repeat (16) begin
			@(posedge clk) #2;
			n = n + tick;
		end
		chk("extclk", 0, n);
		wreg(8'h3D, 8'h01);
		@(posedge clk) #2 chk("trig", 1'b0, tick);
		trig = 1'b1;
		@(posedge clk) #2 chk("trig", 1'b1, tick);
		@(posedge clk) #2 chk("trig", 1'b0, tick);
		trig = 1'b0;
		$display("timer test done");
		{m_en, s_en} = 2'h3;
		wreg(8'h3E, 8'h40);
		ev(0);
		chk("det", 5'h0E, dst);
		reg_host_i.xfer(3'h1, 8'h00, 8'h00, got, k);
		chk("det", 5'h06, dst);
		wreg(8'h3E, 8'h50);
		repeat (2) @(posedge clk);
		#2 chk("chain", 2'h1, chain);
		chk("det", 5'h04, dst);
		ev(1);
		chk("det", 5'h12, dst);
		ev(0);
		chk("det", 5'h1D, dst);
		reg_host_i.xfer(3'h1, 8'h00, 8'h00, got, k);
		chk("det", 5'h05, dst);
		wreg(8'h3E, 8'h60);
		ev(1);
		chk("det", 5'h12, dst);
		@(posedge clk) #2;
		chk("det", 5'h02, dst);
		m_en = 1'b0;
		repeat (2) @(posedge clk);
		#2 chk("chain", 2'h0, chain);
		m_en = 1'b1;
		wreg(8'h3E, 8'h30);
		repeat (2) @(posedge clk);
		#2 chk("chain", 2'h0, chain);
		chk("arm", 2'h3, dst[2:1]);
		$display("chain test done");
		give_verdict;
	end
endmodule
bind timing_measurement_control_config timing_measurement_control_config_assertions timing_measurement_control_config_assertions_i (
	.CLK(CLK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.REG_ACK(REG_ACK), .STATUS_READ(STATUS_READ), .MOTION_DETECT_ENABLE(MOTION_DETECT_ENABLE),
	.MOTION_FLAG(MOTION_FLAG), .SAMPLE_TICK(SAMPLE_TICK),
	.EXTERNAL_CLOCK_ENABLE(EXTERNAL_CLOCK_ENABLE),
	.INTERRUPT_PIN_ONE_DRIVE_EN(INTERRUPT_PIN_ONE_DRIVE_EN),
	.OUTPUT_RATE_SELECT(OUTPUT_RATE_SELECT), .BANDWIDTH_SELECT(BANDWIDTH_SELECT),
	.DETECT_CHAINING_SELECT(DETECT_CHAINING_SELECT));
